// ---- src/rbc_consts.svh ----
// constants for the receive buffer clear request block
`ifndef RBC_CONSTS_SVH
`define RBC_CONSTS_SVH

`define RBC_ADDR_CTRL      12'h000
`define RBC_ADDR_REQ       12'h004
`define RBC_ADDR_STAT      12'h008
`define RBC_ADDR_RESULT0   12'h00C
`define RBC_ADDR_RESULT1   12'h010
`define RBC_ADDR_IRQ_STAT  12'h014
`define RBC_ADDR_IRQ_MASK  12'h018

`define RBC_REQ_TYPE_CLEAR 16'h0004
`define RBC_ERR_NONE       16'h0000
`define RBC_ERR_OVERLAP    16'h7FF0
`define RBC_ERR_PROTOCOL   16'h7FF2
`define RBC_ERR_BAD_REQ    16'h7FF1
`define RBC_CH_FIRST       16'h0001
`define RBC_CH_SECOND      16'h0002

`define RBC_CLEAR_CYCLES   4

`endif

// ---- src/rbc_pkg.sv ----
// types for the receive buffer clear request block
package rbc_pkg;
	typedef enum logic [1:0] {
		RBC_IDLE  = 2'b00,
		RBC_WAIT  = 2'b01,
		RBC_CLEAR = 2'b10,
		RBC_DONE  = 2'b11
	} rbc_state_t;

	// per channel command activity seen from the other command engines
	typedef struct packed {
		logic rx_read_request_flag;
		logic rx_abnormal_detect_flag;
		logic on_call_send_cmd;
		logic plain_send_cmd;
		logic user_frame_send_cmd;
		logic bidir_send_cmd;
		logic bidir_receive_cmd;
		logic module_reinit_cmd;
		logic buffered_receive_cmd;
		logic predefined_protocol_exec_cmd;
	} rbc_chan_act_t;

	typedef struct packed {
		logic done;
		logic error;
	} rbc_flags_t;
endpackage

// ---- src/rbc_receive_buffer_clear.sv ----
// receive buffer clear request interpreter, two channels, AXI4-Lite registers
// Summary of operation
// [R01] channel selector 1 picks first channel, 2 the second; only that area cleared.
// [R02] on completion the status word is zero on success, else an error code.
// [R03] requester puts request-type code 4 in the control block to select clear.
// [R04] control block words 3 to 111 belong to the device; requester never touches them.
// [R05] execution discards every byte held in the selected channel's receive area.
// [R06] the user receive region of the shared buffer memory is left untouched.
// [R07] read request or abnormal flag set holds the clear pending until it drops.
// [R08] overlap with send, reinit or bidir commands fails the later one with 7FF0.
// [R09] clear after an active buffered receive fails 7FF0; the reverse order may run.
// [R10] repeated clear on a busy channel is ignored; other channel runs concurrently.
// [R11] clear on a channel used by the protocol executor fails with 7FF2.
// [R12] done flag pulses one scan, set at end of completing scan.
// [R13] error flag stays low on success, pulses with done on failure.
// [R14] while pending or clearing, flags stay low and status word is not updated; the previous done pulse can still be high while pending.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`include "rbc_consts.svh"
module rbc_receive_buffer_clear #(
	parameter int CLEAR_CYCLES = `RBC_CLEAR_CYCLES
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [11:0]           s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [11:0]           s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  scan_end,
	input  rbc_pkg::rbc_chan_act_t     chan_act [2],
	output logic [1:0]                 clear_cmd_active,
	output logic [1:0]                 rx_area_flush,
	output rbc_pkg::rbc_flags_t        completion_flag_pair [2],
	output logic                       irq
);
	import rbc_pkg::*;

	// the countdown register is eight bits wide and cannot start from zero
	if (CLEAR_CYCLES < 1 || CLEAR_CYCLES > 255) begin : g_bad_cycles
		$error("CLEAR_CYCLES out of range");
	end

	// bus write and read channel holding registers
	logic [11:0] awaddr_q;
	logic        aw_have_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        w_have_q;
	logic        bvalid_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;

	// software state
	logic [15:0] req_type_q;
	logic [15:0] result_q [2];
	logic [3:0]  irq_stat_q;
	logic [3:0]  irq_mask_q;
	rbc_state_t  state_q [2];
	logic [7:0]  cnt_q [2];
	logic [1:0]  finish_q;
	logic [15:0] code_q [2];
	rbc_flags_t  flags_q [2];
	logic [1:0]  flush_q;
	logic        irq_q;

	// write is performed once both address and data are held
	wire         wr_go   = aw_have_q && w_have_q && !bvalid_q;
	wire [31:0]  wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire         wr_ctrl = wr_go && (awaddr_q == `RBC_ADDR_CTRL);
	wire         wr_req  = wr_go && (awaddr_q == `RBC_ADDR_REQ);
	wire         wr_ist  = wr_go && (awaddr_q == `RBC_ADDR_IRQ_STAT);
	wire         wr_imk  = wr_go && (awaddr_q == `RBC_ADDR_IRQ_MASK);
	wire         wr_ok   = wr_ctrl || wr_req || wr_ist || wr_imk;
	wire [31:0]  wval    = wdata_q & wmask;

	// ctrl write: bit0 launches a clear, bits 17:16 carry the channel selector
	wire [15:0]  sel_ch  = {14'h0000, wval[17:16]};
	wire         launch  = wr_ctrl && wval[0];
	wire [1:0]   req_ch;
	assign req_ch[0] = launch && (sel_ch == `RBC_CH_FIRST);  // R01
	assign req_ch[1] = launch && (sel_ch == `RBC_CH_SECOND); // R01

	// error decode shared by both channels
	function automatic logic [15:0] launch_code(input rbc_chan_act_t a, input logic [15:0] rt);
		logic [15:0] c;
		c = `RBC_ERR_NONE;
		if (rt != `RBC_REQ_TYPE_CLEAR) begin
			c = `RBC_ERR_BAD_REQ; // R03
		end else if (a.predefined_protocol_exec_cmd) begin
			c = `RBC_ERR_PROTOCOL; // R11
		end else if (a.on_call_send_cmd || a.plain_send_cmd || a.user_frame_send_cmd ||
			a.bidir_send_cmd || a.bidir_receive_cmd || a.module_reinit_cmd) begin
			c = `RBC_ERR_OVERLAP; // R08
		end else if (a.buffered_receive_cmd) begin
			c = `RBC_ERR_OVERLAP; // R09
		end
		return c;
	endfunction

	// AXI address/data capture, accepted in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 12'h000;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else if (wr_go) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_have_q) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= {s_axi_awaddr[11:2], 2'b00};
			end
			if (s_axi_wvalid && !w_have_q) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
		end
	end

	// write response, slverr on unmapped or read-only address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q    <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else if (wr_go) begin
			bvalid_q    <= 1'b1;
			s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ready outputs as flops: high while the holding slot is free
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !(aw_have_q || (s_axi_awvalid && s_axi_awready)) || wr_go;
			s_axi_wready  <= !(w_have_q || (s_axi_wvalid && s_axi_wready)) || wr_go;
		end
	end

	// software registers; request type and irq mask
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_type_q <= 16'h0000;
			irq_mask_q <= 4'h0;
		end else begin
			if (wr_req) begin
				req_type_q <= wval[15:0];
			end
			if (wr_imk) begin
				irq_mask_q <= wval[3:0];
			end
		end
	end

	// read mux
	logic [31:0] rmux;
	logic        rhit;
	always_comb begin
		rhit = 1'b1;
		unique case ({s_axi_araddr[11:2], 2'b00})
			`RBC_ADDR_CTRL:     rmux = 32'h0000_0000;
			`RBC_ADDR_REQ:      rmux = {16'h0000, req_type_q};
			`RBC_ADDR_STAT:     rmux = {24'h00_0000, state_q[1], state_q[0], flags_q[1],
				flags_q[0]};
			`RBC_ADDR_RESULT0:  rmux = {16'h0000, result_q[0]};
			`RBC_ADDR_RESULT1:  rmux = {16'h0000, result_q[1]};
			`RBC_ADDR_IRQ_STAT: rmux = {28'h000_0000, irq_stat_q};
			`RBC_ADDR_IRQ_MASK: rmux = {28'h000_0000, irq_mask_q};
			default: begin
				rmux = 32'h0000_0000;
				rhit = 1'b0;
			end
		endcase
	end

	// read channel, one read outstanding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q   <= 1'b0;
			rvalid_q    <= 1'b0;
			rdata_q     <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q   <= 1'b0;
			rvalid_q    <= 1'b1;
			rdata_q     <= rmux;
			s_axi_rresp <= rhit ? 2'b00 : 2'b10;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end else begin
			arready_q <= !rvalid_q;
		end
	end

	// per-channel sequencer
	for (genvar c = 0; c < 2; c++) begin : g_ch
		wire [15:0] lcode = launch_code(chan_act[c], req_type_q);
		wire        rx_busy = chan_act[c].rx_read_request_flag || chan_act[c].rx_abnormal_detect_flag;
		// a report waits for the previous pulse to end, so two pulses never merge into one
		wire        report  = scan_end && (state_q[c] == RBC_DONE) && !flags_q[c].done;

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				state_q[c]  <= RBC_IDLE;
				cnt_q[c]    <= 8'h00;
				code_q[c]   <= 16'h0000;
				flush_q[c]  <= 1'b0;
				finish_q[c] <= 1'b0;
			end else begin
				flush_q[c]  <= 1'b0;
				finish_q[c] <= 1'b0;
				unique case (state_q[c])
					RBC_IDLE: begin
						// a new launch while busy falls in the other states and is dropped
						if (req_ch[c]) begin // R10
							code_q[c] <= lcode;
							if (lcode != `RBC_ERR_NONE) begin
								state_q[c] <= RBC_DONE;
							end else begin
								state_q[c] <= RBC_WAIT;
							end
						end
					end
					RBC_WAIT: begin
						// the last pulse must end first, so flags stay low while this clear runs
						if (!rx_busy && !flags_q[c].done) begin // R07
							state_q[c] <= RBC_CLEAR;
							cnt_q[c]   <= CLEAR_CYCLES[7:0];
							flush_q[c] <= 1'b1; // R05
						end
					end
					RBC_CLEAR: begin
						if (cnt_q[c] == 8'h01) begin
							state_q[c] <= RBC_DONE;
						end else begin
							cnt_q[c] <= cnt_q[c] - 8'h01;
						end
					end
					RBC_DONE: begin
						// completion reported at the first scan end at which the done flag is low
						if (report) begin // R12
							state_q[c]  <= RBC_IDLE;
							finish_q[c] <= 1'b1;
						end
					end
				endcase
			end
		end

		// result word and completion flags move only at scan end
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				result_q[c] <= 16'h0000;
				flags_q[c]  <= '0;
			end else if (scan_end) begin
				flags_q[c] <= '0; // R12
				if (report) begin // R14
					result_q[c]      <= code_q[c]; // R02
					flags_q[c].done  <= 1'b1; // R12
					flags_q[c].error <= (code_q[c] != `RBC_ERR_NONE); // R13
				end
			end
		end

		// flush acts on the channel's internal holding area only
		assign rx_area_flush[c]        = flush_q[c]; // R06
		assign completion_flag_pair[c] = flags_q[c];
		assign clear_cmd_active[c]     = (state_q[c] != RBC_IDLE);
	end

	// sticky events: bit c done, bit c+2 error; set beats clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= 4'h0;
			irq_q      <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~(wr_ist ? wval[3:0] : 4'h0)) |
				{code_q[1] != 16'h0000 && finish_q[1], code_q[0] != 16'h0000 && finish_q[0],
				finish_q};
			irq_q      <= |(irq_stat_q & irq_mask_q);
		end
	end

	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign irq           = irq_q;

endmodule // rbc_receive_buffer_clear

// ---- verification/rbc_asserts.sv ----
// port assertions for the clear request block
module rbc_asserts (
	input wire logic		aclk,
	input wire logic		aresetn,
	input wire logic		scan_end,
	input rbc_pkg::rbc_chan_act_t	chan_act [2],
	input wire logic [1:0]		clear_cmd_active,
	input wire logic [1:0]		rx_area_flush,
	input rbc_pkg::rbc_flags_t	completion_flag_pair [2]
);
	timeunit 1ns;
	timeprecision 1ns;
	logic	d0, d1, e0, e1, hold0;
	// short names for the flag pairs and the hold cause
	assign d0 = completion_flag_pair[0].done;
	assign d1 = completion_flag_pair[1].done;
	assign e0 = completion_flag_pair[0].error;
	assign e1 = completion_flag_pair[1].error;
	assign hold0 = chan_act[0].rx_read_request_flag | chan_act[0].rx_abnormal_detect_flag;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// flags live from one scan end to the next
	done_drop_a: assert property (d0 && scan_end |=> !d0)
		else $error("done held past scan end");
	done_rise_a: assert property ($rose(d1) |-> $past(scan_end))
		else $error("done rose off scan end");
	err_pair_a: assert property (e0 |-> d0)
		else $error("error without done");
	err_rise_a: assert property ($rose(e1) |-> $rose(d1))
		else $error("error not with done");
	// flush only once the channel is free, flags quiet meanwhile
	flush_wait_a: assert property (rx_area_flush[0] |-> !$past(hold0))
		else $error("flush while read pending");
	flush_busy_a: assert property (rx_area_flush[1] |-> clear_cmd_active[1])
		else $error("flush on idle channel");
	flush_quiet_a: assert property (rx_area_flush[1] |=> !d1 [*4])
		else $error("flag during clear");
	flush_done_a: assert property (rx_area_flush[0] |-> ##[2:60] d0)
		else $error("clear never completed");
endmodule // rbc_asserts

// ---- verification/rbc_cpu_model.sv ----
// controller side model: scan end pulses and channel activity
module rbc_cpu_model #(
	parameter int SCAN = 20
) (
	input wire logic		aclk,
	input wire logic		aresetn,
	input rbc_pkg::rbc_chan_act_t	act_req [2],
	output logic			scan_end,
	output rbc_pkg::rbc_chan_act_t	chan_act [2]
);
	timeunit 1ns;
	timeprecision 1ns;
	import rbc_pkg::*;
	int	cnt_q;
	// activity follows the request one clock later, on every clock, per channel
	always @(posedge aclk) begin
		cnt_q <= (!aresetn || cnt_q == SCAN - 1) ? 0 : cnt_q + 1;
		scan_end <= aresetn && cnt_q == SCAN - 1;
		chan_act <= act_req;
	end
endmodule // rbc_cpu_model

// ---- verification/test_receive_buffer_clear_request.sv ----
// self-checking bench for the receive buffer clear request block
`include "rbc_consts.svh"
module test_receive_buffer_clear_request;
	timeunit 1ns;
	timeprecision 1ns;
	import rbc_pkg::*;
	logic		aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
	logic [11:0]	awaddr = 0, araddr = 0;
	logic [31:0]	wdata = 0, rdata;
	logic [1:0]	bresp, rresp, active, flush, dprev = 0;
	logic		awready, wready, bvalid, arready, rvalid, scan_end, irq;
	rbc_flags_t	fl [2];
	rbc_chan_act_t	act [2] = '{default: '0}, cact [2];
	logic [33:0]	rq [$];
	logic [1:0]	bq [$];
	logic [15:0]	eq [2][$];
	int		n_mismatch = 0, check_count = 0, ch, nfl = 0;
	always #50 aclk = ~aclk;
	rbc_cpu_model rbc_cpu_model_i (.aclk(aclk), .aresetn(aresetn), .act_req(act),
		.scan_end(scan_end), .chan_act(cact));
	rbc_receive_buffer_clear rbc_receive_buffer_clear_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .scan_end(scan_end),
		.chan_act(cact), .clear_cmd_active(active), .rx_area_flush(flush),
		.completion_flag_pair(fl), .irq(irq));
	task automatic chk(string nm, logic [33:0] got, logic [33:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic tmo;
		n_mismatch++;
		final_report();
	endtask
	// write: address and data offered together, each dropped when taken
	task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er = 2'b00);
		int i;
		bq.push_back(er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awready && awvalid) awvalid <= 0;
			if (wready && wvalid) wvalid <= 0;
			if (bvalid) break;
		end
		if (i == 50) tmo();
	endtask
	// read: the expected word goes to the queue for the watcher
	task automatic rd(logic [11:0] a, logic [33:0] exp);
		int i;
		rq.push_back(exp);
		araddr <= a;
		arvalid <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arready && arvalid) arvalid <= 0;
			if (rvalid) break;
		end
		if (i == 50) tmo();
	endtask
	task automatic launch(int c, logic [31:0] ty, logic [15:0] err);
		wr(`RBC_ADDR_REQ, ty);
		wr(`RBC_ADDR_CTRL, {14'h0000, c[1:0], 16'h0001});
		// only the type and launch words are written, the private area never
		eq[c - 1].push_back(err);
	endtask
	// wait out the completion, then read the stored status word
	task automatic finish_ch(int c, logic [15:0] err);
		int i;
		for (i = 0; i < 400 && (eq[c - 1].size() > 0 || active[c - 1]); i++)
			@(posedge aclk);
		if (i == 400) tmo();
		rd(`RBC_ADDR_RESULT0 + 12'(4 * (c - 1)), {18'h0_0000, err});
	endtask
	// watcher: each result seen is matched against the oldest note
	always @(posedge aclk) begin
		if (rvalid) begin
			if (rq.size() == 0) chk("read", 34'h0, 34'h1);
			else chk("read", {rresp, rdata}, rq.pop_front());
		end
		if (bvalid) begin
			if (bq.size() == 0) chk("bresp", 34'h0, 34'h1);
			else chk("bresp", 34'(bresp), 34'(bq.pop_front()));
		end
		for (int c = 0; c < 2; c++) begin
			if (fl[c].done && !dprev[c]) begin
				if (eq[c].size() == 0) chk("done", 34'h0, 34'h1);
				else chk("err", 34'(fl[c].error), 34'(eq[c].pop_front() != 0));
			end
			dprev[c] = fl[c].done;
			if (flush[c]) nfl++;
		end
	end
	initial begin
		void'($urandom(32'h4167_d9f2));
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		wr(`RBC_ADDR_IRQ_MASK, 32'h0000_0000);
		// pending on read request and abnormal flags, repeat ignored
		act[0].rx_read_request_flag <= 1;
		act[1].rx_abnormal_detect_flag <= 1;
		launch(1, 4, 0);
		launch(2, 4, 0);
		wr(`RBC_ADDR_CTRL, 32'h0001_0001);
		repeat (40) @(posedge aclk);
		chk("held", 34'({active, fl[0].done, fl[1].done}), 34'hc);
		act[0] <= '0;
		act[1] <= '0;
		finish_ch(1, 0);
		finish_ch(2, 0);
		chk("flush", 34'(nfl), 34'h2);
		$display("test pending done");
		// every conflicting command on one channel, other channel free
		for (int b = 0; b < 8; b++) begin
			ch = 1 + $urandom % 2;
			act[ch - 1] <= rbc_chan_act_t'(10'h001 << b);
			repeat (2) @(posedge aclk);
			launch(ch, 4, b == 0 ? `RBC_ERR_PROTOCOL : `RBC_ERR_OVERLAP);
			launch(3 - ch, 4, 0);
			act[ch - 1] <= '0;
			finish_ch(ch, b == 0 ? `RBC_ERR_PROTOCOL : `RBC_ERR_OVERLAP);
			finish_ch(3 - ch, 0);
		end
		chk("flush", 34'(nfl), 34'd10);
		$display("test conflicts done");
		// selector 3 starts nothing; bad request type fails
		wr(`RBC_ADDR_CTRL, 32'h0003_0001);
		repeat (4) @(posedge aclk);
		chk("idle", 34'(active), 34'h0);
		launch(1, 5, `RBC_ERR_BAD_REQ);
		launch(2, 5, `RBC_ERR_BAD_REQ);
		finish_ch(1, `RBC_ERR_BAD_REQ);
		finish_ch(2, `RBC_ERR_BAD_REQ);
		chk("flush", 34'(nfl), 34'd10);
		$display("test bad request done");
		// mask bits enable the line: events pend quietly, then raise it; unmapped refused
		rd(`RBC_ADDR_IRQ_STAT, 34'h0_0000_000f);
		chk("irq", 34'(irq), 34'h0);
		wr(`RBC_ADDR_IRQ_MASK, 32'h0000_000f);
		repeat (3) @(posedge aclk);
		chk("irq", 34'(irq), 34'h1);
		wr(`RBC_ADDR_IRQ_STAT, 32'h0000_000f);
		rd(`RBC_ADDR_IRQ_STAT, 34'h0);
		chk("irq", 34'(irq), 34'h0);
		rd(12'h020, 34'h2_0000_0000);
		wr(12'h020, 32'h0000_0000, 2'b10);
		repeat (3) @(posedge aclk);
		$display("test irq done");
		final_report();
	end
endmodule // test_receive_buffer_clear_request
bind rbc_receive_buffer_clear rbc_asserts rbc_asserts_i (.aclk(aclk), .aresetn(aresetn),
	.scan_end(scan_end), .chan_act(chan_act), .clear_cmd_active(clear_cmd_active),
	.rx_area_flush(rx_area_flush), .completion_flag_pair(completion_flag_pair));
